// ===== verilog/aof_regs.vh
`ifndef AOF_REGS_VH
`define AOF_REGS_VH

// Result width and the extreme codes of the converter.
`define AOF_WIDTH        12
`define AOF_CODE_MIN     12'h000
`define AOF_CODE_MAX     12'hFFF
`define AOF_CODE_MID     12'h7FF
`define AOF_MSB          11

// Sample range classes carried beside each raw sample.
`define AOF_RANGE_IN     2'h0
`define AOF_RANGE_UNDER  2'h1
`define AOF_RANGE_OVER   2'h2

// Output word reset value and FIFO depth.
`define AOF_WORD_RESET   12'h000
`define AOF_FIFO_DEPTH   8
`define AOF_FIFO_AW      3

// Output delay of the word after the capture edge, in ns, and in clocks.
`define AOF_OUT_DELAY_NS 15
`define AOF_CLK_NS       8
`define AOF_OUT_DELAY_CYC ((`AOF_OUT_DELAY_NS + `AOF_CLK_NS - 1) / `AOF_CLK_NS)

`endif

// ===== verilog/aof_fifo.v
`timescale 1ns/100ps
module aof_fifo #(
  parameter WIDTH = 14,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             clk_in,
  input  wire             rst_n_in,
  // Fill side
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  input  wire [WIDTH-1:0] wr_data_in,
  // Drain side
  output wire             rd_valid_out,
  input  wire             rd_ready_in,
  output wire [WIDTH-1:0] rd_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            do_wr;
  wire            do_rd;
  integer         i;

  assign wr_ready_out = (count != DEPTH[AW:0]);
  assign rd_valid_out = (count != {(AW+1){1'b0}});
  assign rd_data_out  = mem[rd_ptr];
  assign do_wr        = wr_valid_in & wr_ready_out;
  assign do_rd        = rd_valid_out & rd_ready_in;

  function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
      ptr_inc = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
    end
  endfunction

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (do_wr) begin
        mem[wr_ptr] <= wr_data_in;
        wr_ptr      <= ptr_inc(wr_ptr);
      end
      if (do_rd) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ===== verilog/aof_coder.v
`timescale 1ns/100ps
`include "aof_regs.vh"
module aof_coder (
  // Raw sample and its range class
  input  wire [11:0] raw_in,
  input  wire [1:0]  range_in,
  // Format select, low selects two's complement
  input  wire        format_select_n_in,
  // Coded result
  output reg  [11:0] code_out,
  output reg         in_range_out
);
  reg [11:0] clamped;

  always @* begin
    clamped      = raw_in;
    in_range_out = 1'b1;
    if (range_in == `AOF_RANGE_UNDER) begin
      clamped      = `AOF_CODE_MIN;
      in_range_out = 1'b0;
    end else if (range_in == `AOF_RANGE_OVER) begin
      clamped      = `AOF_CODE_MAX;
      in_range_out = 1'b0;
    end
    if (format_select_n_in) begin
      code_out = clamped;
    end else begin
      code_out = {~clamped[`AOF_MSB], clamped[`AOF_MSB-1:0]};
    end
  end
endmodule

// ===== verilog/aof_formatter.v
`timescale 1ns/100ps
`include "aof_regs.vh"
module aof_formatter (
  // Clock and reset
  input  wire        clk_in,
  input  wire        reset_n_in,
  // Sample stream from the converter core
  input  wire        sample_valid_in,
  output wire        sample_ready_out,
  input  wire [11:0] sample_raw_in,
  input  wire [1:0]  sample_range_in,
  input  wire        differential_in,
  // Controls
  input  wire        format_select_n_in,
  input  wire        output_enable_n_in,
  input  wire        sample_hold_select_in,
  input  wire        sample_strobe_in,
  // Result pins
  output reg  [11:0] result_bits_out,
  output reg  [11:0] result_bits_oe_out,
  output reg         in_range_flag_out,
  output reg         in_range_flag_oe_out,
  // Status
  output reg         hold_active_out,
  output reg         word_valid_out
);
  // The output stage is a short pipeline: a sample waits in the FIFO, is coded as it
  // leaves, and lands in the output registers on the edge that takes it. Each of the
  // three paths below (word, pin drive, front end mode) has its own small machine, so
  // that a change of enable or mode never disturbs a word that is already standing.

  // Word states; fresh marks the cycle right after a word has been taken.
  localparam [1:0] WS_EMPTY = 2'h0;
  localparam [1:0] WS_FRESH = 2'h1;
  localparam [1:0] WS_STAND = 2'h2;

  // Pin drive states.
  localparam [0:0] DS_FLOAT = 1'h0;
  localparam [0:0] DS_DRIVE = 1'h1;

  // Front end states.
  localparam [0:0] HS_TRACK = 1'h0;
  localparam [0:0] HS_HOLD  = 1'h1;

  // The FIFO word carries the range class above the raw code.
  localparam       FIFO_W   = `AOF_WIDTH + 2;

  // Reset release chain.
  reg         rst_meta;
  reg         rst_sync;

  // FIFO and coder links.
  wire        fifo_ready;
  wire        fifo_push;
  wire        fifo_valid;
  wire [13:0] fifo_data;
  wire [11:0] coded;
  wire        coded_ir;
  wire        take;

  // State registers and their next values.
  reg  [1:0]  word_state;
  reg  [1:0]  next_word_state;
  reg  [0:0]  drive_state;
  reg  [0:0]  next_drive_state;
  reg  [0:0]  hold_state;
  reg  [0:0]  next_hold_state;

  // Next values of the registered outputs.
  reg  [11:0] next_result_bits;
  reg         next_in_range_flag;
  reg  [11:0] next_result_bits_oe;
  reg         next_in_range_flag_oe;
  reg         next_hold_active;
  reg         next_word_valid;

  // True in the drive state; both the result lines and the flag use it.
  function aof_is_drive;
    input [0:0] state;
    begin
      aof_is_drive = (state == DS_DRIVE);
    end
  endfunction

  // One enable level fanned out to every result line.
  function [11:0] aof_fan_enable;
    input drive;
    begin
      aof_fan_enable = {12{drive}};
    end
  endfunction

  // True for the state that follows a taken word.
  function aof_is_fresh;
    input [1:0] state;
    begin
      aof_is_fresh = (state == WS_FRESH);
    end
  endfunction

  // True while the front end holds its samples.
  function aof_is_hold;
    input [0:0] state;
    begin
      aof_is_hold = (state == HS_HOLD);
    end
  endfunction

  // A word leaves the FIFO on an edge that sees both a stored word and the strobe.
  function aof_take;
    input valid;
    input strobe;
    begin
      aof_take = valid & strobe;
    end
  endfunction

  // The external reset is released through two flops so that no register leaves reset
  // on a different edge from its neighbours.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Ready stays low until the reset release has reached the FIFO, so a sample offered
  // during reset is never acknowledged and then lost.
  assign sample_ready_out = fifo_ready & rst_sync;
  assign fifo_push        = sample_valid_in & rst_sync;

  // The differential mode (differential_in) only changes the analog operating point, so it is not looked at here.
  aof_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (`AOF_FIFO_DEPTH),
    .AW    (`AOF_FIFO_AW)
  ) i_aof_fifo (
    .clk_in       (clk_in),
    .rst_n_in     (rst_sync),
    .wr_valid_in  (fifo_push),
    .wr_ready_out (fifo_ready),
    .wr_data_in   ({sample_range_in, sample_raw_in}),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (sample_strobe_in),
    .rd_data_out  (fifo_data)
  );

  // Format is applied when the word leaves the FIFO, so a format change acts on the next word.
  aof_coder i_aof_coder (
    .raw_in             (fifo_data[11:0]),
    .range_in           (fifo_data[13:12]),
    .format_select_n_in (format_select_n_in),
    .code_out           (coded),
    .in_range_out       (coded_ir)
  );

  // A strobe with an empty FIFO is ignored and leaves the last word standing.
  assign take = aof_take(fifo_valid, sample_strobe_in);

  // Word machine.
  always @* begin
    next_word_state = word_state;
    case (word_state)
      WS_EMPTY: begin
        if (take) begin
          next_word_state = WS_FRESH;
        end
      end
      WS_FRESH: begin
        if (take) begin
          next_word_state = WS_FRESH;
        end else begin
          next_word_state = WS_STAND;
        end
      end
      WS_STAND: begin
        if (take) begin
          next_word_state = WS_FRESH;
        end
      end
      default: begin
        if (take) begin
          next_word_state = WS_FRESH;
        end else begin
          next_word_state = WS_EMPTY;
        end
      end
    endcase
  end

  // Word path next values. A word taken while the pins float is still loaded and shows
  // as soon as the enable returns, so the capture side must not count on a float to
  // drop a word.
  always @* begin
    next_result_bits   = result_bits_out;
    next_in_range_flag = in_range_flag_out;
    next_word_valid    = aof_is_fresh(next_word_state);
    if (take) begin
      next_result_bits   = coded;
      next_in_range_flag = coded_ir;
    end
  end

  // Drive machine.
  always @* begin
    next_drive_state = drive_state;
    case (drive_state)
      DS_FLOAT: begin
        if (!output_enable_n_in) begin
          next_drive_state = DS_DRIVE;
        end
      end
      DS_DRIVE: begin
        if (output_enable_n_in) begin
          next_drive_state = DS_FLOAT;
        end
      end
      default: begin
        next_drive_state = DS_FLOAT;
      end
    endcase
  end

  // Pin drive next values; the flag floats and drives together with the result lines.
  always @* begin
    next_result_bits_oe   = aof_fan_enable(aof_is_drive(next_drive_state));
    next_in_range_flag_oe = aof_is_drive(next_drive_state);
  end

  // Front end machine: follows the sample-hold select one clock late.
  always @* begin
    next_hold_state = hold_state;
    case (hold_state)
      HS_TRACK: begin
        if (sample_hold_select_in) begin
          next_hold_state = HS_HOLD;
        end
      end
      HS_HOLD: begin
        if (!sample_hold_select_in) begin
          next_hold_state = HS_TRACK;
        end
      end
      default: begin
        next_hold_state = HS_TRACK;
      end
    endcase
    next_hold_active = aof_is_hold(next_hold_state);
  end

  // Word registers.
  always @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      word_state        <= WS_EMPTY;
      result_bits_out   <= `AOF_WORD_RESET;
      in_range_flag_out <= 1'b0;
      word_valid_out    <= 1'b0;
    end else begin
      word_state        <= next_word_state;
      result_bits_out   <= next_result_bits;
      in_range_flag_out <= next_in_range_flag;
      word_valid_out    <= next_word_valid;
    end
  end

  // Pin drive registers. After reset every line floats until the enable has been seen
  // low on a clock edge, so the pins never glitch out of reset.
  always @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      drive_state          <= DS_FLOAT;
      result_bits_oe_out   <= 12'h000;
      in_range_flag_oe_out <= 1'b0;
    end else begin
      drive_state          <= next_drive_state;
      result_bits_oe_out   <= next_result_bits_oe;
      in_range_flag_oe_out <= next_in_range_flag_oe;
    end
  end

  // Front end registers.
  always @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      hold_state      <= HS_TRACK;
      hold_active_out <= 1'b0;
    end else begin
      hold_state      <= next_hold_state;
      hold_active_out <= next_hold_active;
    end
  end
endmodule

// ===== verification/aof_capture.sv
`timescale 1ns/100ps
module aof_capture (
  // Clock and pacing
  input  wire        clk_in,
  input  wire        go_in,
  // Result pins
  input  wire        word_valid_in,
  input  wire [11:0] bits_in,
  input  wire        flag_in,
  // Sample clock and captured word
  output reg         strobe_out,
  output reg  [11:0] word_out,
  output reg         flag_out,
  output reg         seen_out
);
  // Parked high so the sample clock never floats at power-up.
  initial strobe_out = 1'b1;
  always @(posedge clk_in) begin
    strobe_out <= go_in;
    seen_out <= word_valid_in;
    if (word_valid_in) begin
      word_out <= bits_in;
      flag_out <= flag_in;
    end
  end
endmodule

// ===== verification/aof_formatter_properties.sv
`timescale 1ns/100ps
module aof_formatter_properties (
  input wire        clk_in,
  input wire        reset_n_in,
  input wire        sample_strobe_in,
  input wire        output_enable_n_in,
  input wire        format_select_n_in,
  input wire        sample_hold_select_in,
  input wire        sample_ready_out,
  input wire [11:0] result_bits_out,
  input wire [11:0] result_bits_oe_out,
  input wire        in_range_flag_out,
  input wire        in_range_flag_oe_out,
  input wire        hold_active_out,
  input wire        word_valid_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_oe_lag: assert property ($past(reset_n_in, 3) |->
    result_bits_oe_out == {12{!$past(output_enable_n_in)}}) else $error("oe lag");
  a_flag_oe: assert property (in_range_flag_oe_out == result_bits_oe_out[11])
    else $error("flag oe");
  a_hold_copy: assert property ($past(reset_n_in, 3) |->
    hold_active_out == $past(sample_hold_select_in)) else $error("hold");
  a_word_stands: assert property (!word_valid_out |-> $stable(result_bits_out))
    else $error("word moved");
  a_pop_cause: assert property (word_valid_out |-> $past(sample_strobe_in))
    else $error("pop");
  a_one_pulse: assert property (word_valid_out && !sample_strobe_in |=> !word_valid_out)
    else $error("pulse");
  a_clamp_code: assert property (word_valid_out && !in_range_flag_out |->
    result_bits_out[10:0] == {11{result_bits_out[11] ~^ $past(format_select_n_in)}})
    else $error("clamp");
  a_ready_rst: assert property (!$past(reset_n_in) |-> !sample_ready_out)
    else $error("ready");
  c_clamp: cover property (word_valid_out && !in_range_flag_out);
  c_full: cover property (!sample_ready_out && sample_strobe_in);
  c_float: cover property (result_bits_oe_out == 12'h000);
endmodule
bind aof_formatter aof_formatter_properties i_aof_formatter_properties (
  .clk_in                (clk_in),
  .reset_n_in            (reset_n_in),
  .sample_strobe_in      (sample_strobe_in),
  .output_enable_n_in    (output_enable_n_in),
  .format_select_n_in    (format_select_n_in),
  .sample_hold_select_in (sample_hold_select_in),
  .sample_ready_out      (sample_ready_out),
  .result_bits_out       (result_bits_out),
  .result_bits_oe_out    (result_bits_oe_out),
  .in_range_flag_out     (in_range_flag_out),
  .in_range_flag_oe_out  (in_range_flag_oe_out),
  .hold_active_out       (hold_active_out),
  .word_valid_out        (word_valid_out)
);

// ===== verification/tb_aof_formatter.sv
`timescale 1ns/100ps
module tb_aof_formatter;
  localparam [83:0] CASES = {14'h3001, 14'h2456, 14'h1123, 14'h0FFF, 14'h07FF, 14'h0000};
  reg         clk_in = 1'b0;
  reg         reset_n_in = 1'b0;
  reg         sample_valid_in = 1'b0;
  reg  [11:0] sample_raw_in = 12'h000;
  reg  [1:0]  sample_range_in = 2'h0;
  reg         differential_in = 1'b0;
  reg         format_select_n_in = 1'b1;
  reg         output_enable_n_in = 1'b0;
  reg         sample_hold_select_in = 1'b1;
  reg         go = 1'b0;
  wire        sample_ready_out, sample_strobe_in, in_range_flag_out, in_range_flag_oe_out;
  wire        hold_active_out, word_valid_out, flag, seen;
  wire [11:0] result_bits_out, result_bits_oe_out, word;
  integer     mismatches = 0, tests_run = 0, k, w;
  always #4 clk_in = ~clk_in;
  aof_formatter i_aof_formatter (
    .clk_in                (clk_in),
    .reset_n_in            (reset_n_in),
    .sample_valid_in       (sample_valid_in),
    .sample_ready_out      (sample_ready_out),
    .sample_raw_in         (sample_raw_in),
    .sample_range_in       (sample_range_in),
    .differential_in       (differential_in),
    .format_select_n_in    (format_select_n_in),
    .output_enable_n_in    (output_enable_n_in),
    .sample_hold_select_in (sample_hold_select_in),
    .sample_strobe_in      (sample_strobe_in),
    .result_bits_out       (result_bits_out),
    .result_bits_oe_out    (result_bits_oe_out),
    .in_range_flag_out     (in_range_flag_out),
    .in_range_flag_oe_out  (in_range_flag_oe_out),
    .hold_active_out       (hold_active_out),
    .word_valid_out        (word_valid_out)
  );
  aof_capture i_aof_capture (.clk_in(clk_in), .go_in(go), .word_valid_in(word_valid_out),
    .bits_in(result_bits_out), .flag_in(in_range_flag_out), .strobe_out(sample_strobe_in),
    .word_out(word), .flag_out(flag), .seen_out(seen));
  function [12:0] ex(input [13:0] s, input f);
    reg [11:0] c;
    begin
      c = s[13:12] == 2'h1 ? 12'h000 : s[13:12] == 2'h2 ? 12'hFFF : s[11:0];
      ex = {s[13:12] != 2'h1 && s[13:12] != 2'h2, c[11] ^ ~f, c[10:0]};
    end
  endfunction
  task conclude;
    begin
      $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task check(input [12:0] got, input [12:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task push(input [13:0] s);
    begin
      sample_valid_in = 1'b1;
      {sample_range_in, sample_raw_in} = s;
      for (w = 0; w < 9 && !sample_ready_out; w = w + 1) @(posedge clk_in) #1;
      check({12'h000, sample_ready_out}, 13'h0001);
      if (sample_ready_out !== 1'b1) begin
        conclude;
      end else begin
        @(posedge clk_in) #1;
      end
    end
  endtask
  // The far side paces pops; a word that never comes ends the run.
  task pop(input [12:0] e);
    begin
      go = 1'b1;
      @(posedge clk_in) #1;
      go = 1'b0;
      for (w = 0; w < 9 && !seen; w = w + 1) @(posedge clk_in) #1;
      if (seen !== 1'b1) begin
        mismatches = mismatches + 1;
        conclude;
      end else begin
        check({flag, word}, e);
      end
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    #1 reset_n_in = 1'b1;
    repeat (3) @(posedge clk_in) #1;
    for (k = 0; k < 12; k = k + 1) begin
      format_select_n_in = k[0];
      differential_in = k[1];
      push(CASES[k / 2 * 14 +: 14]);
      sample_valid_in = 1'b0;
      pop(ex(CASES[k / 2 * 14 +: 14], k[0]));
    end
    for (k = 0; k < 8; k = k + 1) push(14'h111 * k);
    @(posedge clk_in) #1;
    check({12'h000, sample_ready_out}, 13'h0000);
    sample_valid_in = 1'b0;
    for (k = 0; k < 8; k = k + 1) pop({1'b1, 12'h111 * k[11:0]});
    output_enable_n_in = 1'b1;
    sample_hold_select_in = 1'b0;
    repeat (2) @(posedge clk_in) #1;
    check({in_range_flag_oe_out | hold_active_out, result_bits_oe_out}, 13'h0000);
    output_enable_n_in = 1'b0;
    sample_hold_select_in = 1'b1;
    repeat (2) @(posedge clk_in) #1;
    check({hold_active_out & in_range_flag_oe_out, result_bits_oe_out}, 13'h1FFF);
    conclude;
  end
endmodule
